//--- common/eqlk_consts.svh
// Constants for the equalizer lock and mode control block.
`ifndef EQLK_CONSTS_SVH
`define EQLK_CONSTS_SVH
`define EQLK_ADDR_CTRL 8'h00
`define EQLK_ADDR_STATUS 8'h04
`define EQLK_ADDR_INT_STAT 8'h08
`define EQLK_ADDR_INT_MASK 8'h0c
`define EQLK_CTRL_RESET 3'h6
`define EQLK_LOCK_LINES 100
`define EQLK_EQ_INIT 6'h00
`define EQLK_TOGGLE_MIN_NS 1000000
`define EQLK_CLK_NS 5
`define EQLK_TOGGLE_CYC ((`EQLK_TOGGLE_MIN_NS + `EQLK_CLK_NS - 1) / `EQLK_CLK_NS)
`endif

//--- common/eqlk_pkg.sv
// Types for the equalizer lock and mode control block.
package eqlk_pkg;
  typedef enum logic {EQLK_ADAPT, EQLK_LOCK_INDICATOR} eqlk_state_t;
  typedef logic [5:0] eqlk_eq_t;
endpackage : eqlk_pkg

//--- hdl/eqlk_top.sv
// Lock and mode control around an adaptive cable equalizer, with an APB register file.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "eqlk_consts.svh"
module eqlk_top #(
  parameter int LOCK_LINES = `EQLK_LOCK_LINES,
  parameter int TOGGLE_CYC = `EQLK_TOGGLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic freeze_pin,
  input wire logic line_sync,
  input wire logic sig_present,
  input wire logic eq_up_req,
  input wire logic eq_dn_req,
  input wire logic pol_swap_det,
  input wire logic color_det,
  input wire logic invert_pin_i,
  output logic invert_pin_o,
  output logic invert_pin_oe,
  input wire logic color_pin_i,
  output logic color_pin_o,
  output logic color_pin_oe,
  output logic lock_indicator,
  output eqlk_pkg::eqlk_eq_t eq_setting,
  output logic invert_path,
  output logic use_burst,
  output logic irq
);
  import eqlk_pkg::*;

  localparam int NS = 9;
  localparam logic [17:0] TOG_MAX = 18'(TOGGLE_CYC);
  localparam logic [6:0] LINES_LAST = 7'(LOCK_LINES - 1);

  logic [NS-1:0] async_in;
  logic [NS-1:0] sync1_reg;
  logic [NS-1:0] sync2_reg;
  logic line_prev_reg;
  logic freeze_s, line_s, sig_s, up_s, dn_s, pol_s, col_s, inv_pin_s, col_pin_s;
  logic line_edge;

  // All pin inputs pass two flip-flops before any logic looks at them.
  assign async_in = {freeze_pin, line_sync, sig_present, eq_up_req, eq_dn_req,
                     pol_swap_det, color_det, invert_pin_i, color_pin_i};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      line_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
      line_prev_reg <= sync2_reg[7];
    end
  end
  assign {freeze_s, line_s, sig_s, up_s, dn_s, pol_s, col_s, inv_pin_s, col_pin_s} = sync2_reg;
  assign line_edge = line_s & ~line_prev_reg;

  // Register state.
  logic [2:0] ctrl_reg, ctrl_next;
  logic [2:0] int_stat_reg, int_stat_next;
  logic [2:0] int_mask_reg, int_mask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic irq_reg, irq_next;
  logic sw_restart;
  logic wr_done;
  logic hit;

  // Control and adaptation state.
  eqlk_state_t state_reg, state_next;
  logic [6:0] lines_reg, lines_next;
  eqlk_eq_t eq_reg, eq_next;
  logic lock_reg, lock_next;
  logic [17:0] tog_cnt_reg, tog_cnt_next;
  logic inv_o_reg, inv_o_next;
  logic col_o_reg, col_o_next;
  logic inv_path_reg, inv_path_next;
  logic burst_reg, burst_next;
  logic mism;
  logic restart;
  logic step;

  // An overdriven polarity pin differs from what the device drives.
  assign mism = inv_pin_s ^ inv_o_reg;
  // Restart fires when a long enough overdrive is released, or on software request.
  assign restart = (~mism & (tog_cnt_reg >= TOG_MAX)) | sw_restart;
  assign step = (up_s & (eq_reg != 6'h3f)) | (dn_s & ~up_s & (eq_reg != 6'h00));

  // Next-state logic for lock control, toggle timer and pin drivers.
  always_comb begin
    state_next = state_reg;
    lines_next = lines_reg;
    eq_next = eq_reg;
    tog_cnt_next = 18'h00000;
    if (mism) begin
      tog_cnt_next = (tog_cnt_reg >= TOG_MAX) ? tog_cnt_reg : tog_cnt_reg + 18'h00001;
    end
    inv_o_next = pol_s;
    col_o_next = col_s;
    inv_path_next = inv_pin_s;
    burst_next = col_pin_s;
    if (restart) begin
      state_next = EQLK_ADAPT;
      lines_next = 7'h00;
      eq_next = `EQLK_EQ_INIT;
    end else begin
      case (state_reg)
        EQLK_ADAPT: begin
          if (!sig_s) begin
            lines_next = 7'h00;
          end else if (line_edge) begin
            if (step) begin
              eq_next = up_s ? eq_reg + 6'h01 : eq_reg - 6'h01;
              lines_next = 7'h00;
            end else if (lines_reg == LINES_LAST) begin
              state_next = EQLK_LOCK_INDICATOR;
              lines_next = 7'h00;
            end else begin
              lines_next = lines_reg + 7'h01;
            end
          end
        end
        EQLK_LOCK_INDICATOR: begin
          // Freeze high holds everything; freeze low keeps adapting.
          if (!freeze_s) begin
            if (!sig_s) begin
              state_next = EQLK_ADAPT;
            end else if (line_edge && step) begin
              eq_next = up_s ? eq_reg + 6'h01 : eq_reg - 6'h01;
              state_next = EQLK_ADAPT;
            end
          end
        end
        default: begin
          state_next = EQLK_ADAPT;
        end
      endcase
    end
    lock_next = (state_next == EQLK_LOCK_INDICATOR);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= EQLK_ADAPT;
      lines_reg <= 7'h00;
      eq_reg <= `EQLK_EQ_INIT;
      lock_reg <= 1'b0;
      tog_cnt_reg <= 18'h00000;
      inv_o_reg <= 1'b0;
      col_o_reg <= 1'b0;
      inv_path_reg <= 1'b0;
      burst_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      lines_reg <= lines_next;
      eq_reg <= eq_next;
      lock_reg <= lock_next;
      tog_cnt_reg <= tog_cnt_next;
      inv_o_reg <= inv_o_next;
      col_o_reg <= col_o_next;
      inv_path_reg <= inv_path_next;
      burst_reg <= burst_next;
    end
  end

  // APB slave: one wait cycle, writes land at the completing edge.
  assign hit = (paddr == `EQLK_ADDR_CTRL) || (paddr == `EQLK_ADDR_STATUS) ||
               (paddr == `EQLK_ADDR_INT_STAT) || (paddr == `EQLK_ADDR_INT_MASK);
  assign wr_done = psel & penable & pready_reg & pwrite & hit;
  assign sw_restart = wr_done & (paddr == `EQLK_ADDR_CTRL) & pwdata[0];

  always_comb begin
    pready_next = psel & penable & ~pready_reg;
    pslverr_next = psel & penable & ~pready_reg & ~hit;
    prdata_next = prdata_reg;
    ctrl_next = ctrl_reg;
    int_mask_next = int_mask_reg;
    int_stat_next = int_stat_reg;
    if (pready_next) begin
      case (paddr)
        `EQLK_ADDR_CTRL: prdata_next = {29'h0, ctrl_reg[2:1], 1'b0};
        `EQLK_ADDR_STATUS: prdata_next = {11'h0, lines_reg, eq_reg,
                                         3'h0, burst_reg, inv_path_reg, freeze_s, 1'b0,
                                         lock_reg};
        `EQLK_ADDR_INT_STAT: prdata_next = {29'h0, int_stat_reg};
        `EQLK_ADDR_INT_MASK: prdata_next = {29'h0, int_mask_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end
    if (wr_done && paddr == `EQLK_ADDR_CTRL) begin
      ctrl_next = {pwdata[2:1], 1'b0};
    end
    if (wr_done && paddr == `EQLK_ADDR_INT_MASK) begin
      int_mask_next = pwdata[2:0];
    end
    if (wr_done && paddr == `EQLK_ADDR_INT_STAT) begin
      int_stat_next = int_stat_reg & ~pwdata[2:0];
    end
    // Events set after the clear so a same-cycle event is kept.
    int_stat_next = int_stat_next | {restart, lock_reg & ~lock_next, ~lock_reg & lock_next};
    irq_next = |(int_stat_next & int_mask_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `EQLK_CTRL_RESET;
      int_stat_reg <= 3'h0;
      int_mask_reg <= 3'h0;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      int_stat_reg <= int_stat_next;
      int_mask_reg <= int_mask_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg <= irq_next;
    end
  end

  // Output drivers, all from flip-flops.
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign invert_pin_o = inv_o_reg;
  assign invert_pin_oe = ctrl_reg[1];
  assign color_pin_o = col_o_reg;
  assign color_pin_oe = ctrl_reg[2];
  assign lock_indicator = lock_reg;
  assign eq_setting = eq_reg;
  assign invert_path = inv_path_reg;
  assign use_burst = burst_reg;
  assign irq = irq_reg;

  // Checks on the lock control and on the polarity and burst pin paths.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_hold_eq;
    state_reg == EQLK_LOCK_INDICATOR && freeze_s && !restart |=> $stable(eq_reg);
  endproperty
  a_hold_eq: assert property (p_hold_eq) else $error("Equalization moved while frozen.");

  property p_hold_lock;
    state_reg == EQLK_LOCK_INDICATOR && freeze_s && !sig_s && !restart |=> state_reg == EQLK_LOCK_INDICATOR;
  endproperty
  a_hold_lock: assert property (p_hold_lock) else $error("Lock lost in hold mode.");

  property p_restart;
    restart |=> state_reg == EQLK_ADAPT && eq_reg == `EQLK_EQ_INIT ##1 !lock_reg;
  endproperty
  a_restart: assert property (p_restart) else $error("Restart did not reset adaptation.");

  property p_timer;
    (restart && !sw_restart) |-> $past(mism) && $past(tog_cnt_reg) >= TOG_MAX - 18'h00001;
  endproperty
  a_timer: assert property (p_timer) else $error("Restart without a timed toggle.");

  property p_cont;
    state_reg == EQLK_LOCK_INDICATOR && !freeze_s && !sig_s |=> state_reg == EQLK_ADAPT;
  endproperty
  a_cont: assert property (p_cont) else $error("Continuous mode kept a lost lock.");

  property p_lock_lines;
    $rose(state_reg == EQLK_LOCK_INDICATOR) |-> $past(lines_reg) == LINES_LAST && $past(line_edge);
  endproperty
  a_lock_lines: assert property (p_lock_lines) else $error("Lock before settled lines.");

  property p_pol_out;
    invert_pin_o == $past(sync2_reg[3]);
  endproperty
  a_pol_out: assert property (p_pol_out) else $error("Polarity pin not detector.");

  property p_inv_path;
    ##3 invert_path == $past(invert_pin_i, 3);
  endproperty
  a_inv_path: assert property (p_inv_path) else $error("Inversion not following pin.");

  property p_col_out;
    color_pin_o == $past(sync2_reg[2]);
  endproperty
  a_col_out: assert property (p_col_out) else $error("Burst pin not detector.");

  property p_burst;
    ##3 use_burst == $past(color_pin_i, 3);
  endproperty
  a_burst: assert property (p_burst) else $error("Burst use not following pin.");

  c_lock: cover property ($rose(lock_indicator));
  c_restart: cover property (restart && !sw_restart);
  c_unlock: cover property ($fell(lock_indicator) && !freeze_s);
endmodule : eqlk_top
`default_nettype wire

//--- sim/eqlk_partner.sv
// Board-side model of the strapping and external logic on the block's pins.
`timescale 1ns/1ps
`default_nettype none
module eqlk_partner (
  input wire logic lock_indicator,
  input wire logic tie_en,
  output logic freeze_pin,
  input wire logic invert_pin_o,
  input wire logic invert_pin_oe,
  input wire logic inv_frc_en,
  input wire logic inv_frc_val,
  output logic invert_pin_i,
  input wire logic color_pin_o,
  input wire logic color_pin_oe,
  input wire logic col_frc_en,
  input wire logic col_frc_val,
  output logic color_pin_i
);
  // Strapping the lock output onto freeze selects hold-after-lock mode.
  assign freeze_pin = tie_en ? lock_indicator : 1'b0;
  // An outside driver wins over the device; an undriven pin shows the inverse level.
  assign invert_pin_i = inv_frc_en ? inv_frc_val : (invert_pin_oe ? invert_pin_o : ~invert_pin_o);
  assign color_pin_i = col_frc_en ? col_frc_val : (color_pin_oe ? color_pin_o : ~color_pin_o);
endmodule : eqlk_partner
`default_nettype wire

//--- sim/equalizer_lock_mode_control_bench.sv
// Self-checking bench for the equalizer lock and mode control block.
`timescale 1ns/1ps
`default_nettype none
module equalizer_lock_mode_control_bench;
  import eqlk_pkg::*;
  localparam int LL = 4;
  localparam int TC = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, freeze_pin, line_sync, sig_present;
  logic eq_up_req, eq_dn_req, pol_swap_det, color_det, invert_pin_i, invert_pin_o, invert_pin_oe;
  logic color_pin_i, color_pin_o, color_pin_oe, lock_indicator, invert_path, use_burst, irq;
  logic tie_en, inv_frc_en, inv_frc_val, col_frc_en, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  eqlk_eq_t eq_setting, eq_prev;
  int mismatches, comparisons;
  eqlk_top #(.LOCK_LINES(LL), .TOGGLE_CYC(TC)) DUT (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .freeze_pin(freeze_pin),
    .line_sync(line_sync), .sig_present(sig_present), .eq_up_req(eq_up_req),
    .eq_dn_req(eq_dn_req),
    .pol_swap_det(pol_swap_det), .color_det(color_det), .invert_pin_i(invert_pin_i),
    .invert_pin_o(invert_pin_o), .invert_pin_oe(invert_pin_oe), .color_pin_i(color_pin_i),
    .color_pin_o(color_pin_o), .color_pin_oe(color_pin_oe), .lock_indicator(lock_indicator),
    .eq_setting(eq_setting), .invert_path(invert_path), .use_burst(use_burst), .irq(irq));
  eqlk_partner board (.lock_indicator(lock_indicator), .tie_en(tie_en), .freeze_pin(freeze_pin),
    .invert_pin_o(invert_pin_o), .invert_pin_oe(invert_pin_oe), .inv_frc_en(inv_frc_en),
    .inv_frc_val(inv_frc_val), .invert_pin_i(invert_pin_i), .color_pin_o(color_pin_o),
    .color_pin_oe(color_pin_oe), .col_frc_en(col_frc_en), .col_frc_val(1'b0),
    .color_pin_i(color_pin_i));
  // Free-running 200 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Compares one value with its expectation and counts the outcome.
  task chk(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  // One APB transfer; holds the request until pready is seen high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Sends n video lines, each with the given step request.
  task lines(input int n, input logic up);
    repeat (n) begin
      @(posedge pclk);
      eq_up_req <= up;
      line_sync <= 1'b1;
      repeat (6) @(posedge pclk);
      line_sync <= 1'b0;
      repeat (6) @(posedge pclk);
    end
    eq_up_req <= 1'b0;
  endtask : lines
  // Overdrives the polarity pin to the opposite level for n clocks.
  task toggle(input int n);
    @(posedge pclk);
    inv_frc_val <= ~invert_pin_o;
    inv_frc_en <= 1'b1;
    repeat (n) @(posedge pclk);
    chk(invert_path, inv_frc_val);
    inv_frc_en <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : toggle
  // Reset values, refused address and the pin detectors with overdrive.
  task t_reset_pins;
    apb(1'b0, 8'h00, 32'h0);
    chk(r, 32'h6);
    apb(1'b0, 8'h10, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    pol_swap_det <= 1'b1;
    color_det <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(invert_pin_o, 1'b1);
    chk(invert_path, 1'b1);
    chk(color_pin_o, 1'b1);
    chk(use_burst, 1'b1);
    col_frc_en <= 1'b1;
    pol_swap_det <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(use_burst, 1'b0);
    chk(invert_pin_o, 1'b0);
    col_frc_en <= 1'b0;
  endtask : t_reset_pins
  // Continuous mode locks after exactly LL quiet lines and unlocks on a step.
  task t_continuous;
    lines(LL - 1, 1'b0);
    chk(lock_indicator, 1'b0);
    lines(1, 1'b0);
    chk(lock_indicator, 1'b1);
    lines(1, 1'b1);
    chk(lock_indicator, 1'b0);
    eq_prev = eq_setting;
    lines(1, 1'b1);
    chk(eq_setting, eq_prev + 6'h01);
    eq_dn_req <= 1'b1;
    lines(1, 1'b0);
    eq_dn_req <= 1'b0;
    chk(eq_setting, 32'h1);
    lines(LL, 1'b0);
    chk(lock_indicator, 1'b1);
    sig_present <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(lock_indicator, 1'b0);
    sig_present <= 1'b1;
  endtask : t_continuous
  // Hold mode keeps lock and setting through steps and signal loss.
  task t_hold;
    tie_en <= 1'b1;
    lines(LL, 1'b0);
    chk(lock_indicator, 1'b1);
    eq_prev = eq_setting;
    sig_present <= 1'b0;
    lines(2, 1'b1);
    chk(lock_indicator, 1'b1);
    chk(eq_setting, eq_prev);
    sig_present <= 1'b1;
  endtask : t_hold
  // Short overdrive is ignored; a long one restarts and raises the interrupt.
  task t_restart;
    apb(1'b1, 8'h08, 32'h7);
    apb(1'b1, 8'h0c, 32'h4);
    toggle(TC / 2);
    chk(lock_indicator, 1'b1);
    // A source switch in hold mode shows as a short signal loss before the restart.
    sig_present <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(lock_indicator, 1'b1);
    sig_present <= 1'b1;
    toggle(TC + 10);
    chk({lock_indicator, eq_setting}, {1'b0, 6'h00});
    chk(irq, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk(r[2], 1'b1);
    apb(1'b1, 8'h08, 32'h4);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
  endtask : t_restart
  // Software restart, pin enables, status layout and an undriven polarity pin.
  task t_regs;
    apb(1'b0, 8'h0c, 32'h0);
    chk(r, 32'h4);
    apb(1'b1, 8'h00, 32'h7);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b0, 8'h00, 32'h0);
    chk(r, 32'h6);
    apb(1'b1, 8'h08, 32'h7);
    apb(1'b1, 8'h00, 32'h0);
    repeat (24) @(posedge pclk);
    chk(invert_pin_oe, 1'b0);
    chk(color_pin_oe, 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    chk(r, 32'h8);
    apb(1'b1, 8'h00, 32'h6);
    repeat (8) @(posedge pclk);
    chk(invert_pin_oe, 1'b1);
    chk(color_pin_oe, 1'b1);
    chk(irq, 1'b1);
  endtask : t_regs
  // Prints the counts and the verdict, then ends the run.
  task summarize;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  // Main sequence: reset for four clocks, then the scenarios.
  initial begin
    {presetn, psel, penable, pwrite, line_sync, eq_up_req, pol_swap_det, color_det} = 8'h00;
    {tie_en, inv_frc_en, inv_frc_val, col_frc_en} = 4'h0;
    sig_present = 1'b1;
    eq_dn_req = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    comparisons = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset_pins();
    t_continuous();
    t_hold();
    t_restart();
    t_regs();
    summarize();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    summarize();
  end
endmodule : equalizer_lock_mode_control_bench
`default_nettype wire
